// ==== ssccm_peer.sv ====
/*
  Far-side serial peer: bit clock and a byte counter sent MSB first.
  Assumes the bench raises en_i for the length of a frame.
*/
`timescale 1ns/1ps
module ssccm_peer (
  // Clock and frame enable
  input wire logic clk_i,
  input wire logic en_i,
  // Pads
  output logic ck_o,
  output logic rd_o
);
  logic [5:0] ph_r;
  logic [7:0] word_r;
  // Bit clock at clk/8, within the pad limits, stands low between frames
  always_ff @(posedge clk_i) begin
    ph_r <= en_i ? ph_r + 6'h01 : 6'h00;
    word_r <= !en_i ? 8'h00 : (ph_r == 6'h3F) ? word_r + 8'h01 : word_r;
  end
  assign ck_o = en_i && ph_r[2];
  // Data moves on the falling edge; released line shows the inverse
  assign rd_o = en_i ? word_r[3'h7 - ph_r[5:3]] : ~word_r[0];
endmodule

// ==== ssccm_pkg.sv ====
/*
  Shared constants and carrier types for the serial clock management block.
  Assumes a single 100 MHz clock and a classic Wishbone slave with 32-bit data.
*/
package ssccm_pkg;

  // Register byte offsets
  localparam logic [7:0] SSCCM_DIV_OFS = 8'h00;
  localparam logic [7:0] SSCCM_TCM_OFS = 8'h04;
  localparam logic [7:0] SSCCM_RCM_OFS = 8'h08;
  localparam logic [7:0] SSCCM_STAT_OFS = 8'h0C;
  localparam logic [7:0] SSCCM_MASK_OFS = 8'h10;

  // Divider field
  localparam int SSCCM_DIV_W = 12;
  localparam logic [11:0] SSCCM_DIV_RST = 12'h000;

  // Clock mode field positions
  localparam int SSCCM_SRC_LSB = 0;
  localparam int SSCCM_OUT_LSB = 2;
  localparam int SSCCM_INV_BIT = 4;
  localparam int SSCCM_SYNC_BIT = 5;
  localparam int SSCCM_MODE_W = 6;
  localparam logic [5:0] SSCCM_MODE_RST = 6'h00;

  // Clock source encodings
  localparam logic [1:0] SSCCM_SRC_DIV = 2'h0;
  localparam logic [1:0] SSCCM_SRC_OTHER = 2'h1;
  localparam logic [1:0] SSCCM_SRC_PAD = 2'h2;

  // Clock output encodings
  localparam logic [1:0] SSCCM_OUT_NONE = 2'h0;
  localparam logic [1:0] SSCCM_OUT_CONT = 2'h1;
  localparam logic [1:0] SSCCM_OUT_XFER = 2'h2;

  // Status bit positions
  localparam int SSCCM_ST_RXAV = 0;
  localparam int SSCCM_ST_FULL = 1;
  localparam int SSCCM_ST_OVR = 2;
  localparam int SSCCM_ST_TFS = 3;
  localparam int SSCCM_ST_RFS = 4;
  localparam int SSCCM_ST_W = 5;
  localparam logic [4:0] SSCCM_MASK_RST = 5'h00;

  // Receive buffer shape
  localparam int SSCCM_WORD_W = 8;
  localparam int SSCCM_FIFO_D = 16;

  // Pad inputs, sampled through synchronisers on clk_i
  typedef struct packed {
    logic rd;
    logic tx_fs;
    logic rx_fs;
    logic tx_clk;
    logic rx_clk;
  } ssccm_pad_in_t;

  // Clock pad drive
  typedef struct packed {
    logic rx_clk_o;
    logic rx_clk_oe;
    logic tx_clk_o;
    logic tx_clk_oe;
  } ssccm_pad_out_t;

  // Internal clock events handed to the shifters
  typedef struct packed {
    logic tx_level;
    logic tx_rise;
    logic tx_fall;
    logic tx_start;
    logic rx_level;
    logic rx_rise;
    logic rx_fall;
    logic rx_start;
  } ssccm_clk_evt_t;

endpackage

// ==== ssccm_top.sv ====
/*
  Clock divider, clock source selection, inversion, clock pad drive and interrupt
  front end of the synchronous serial controller, with a receive word buffer.
  Assumes pads are sampled on clk_i and a classic Wishbone master.
*/
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

module ssccm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill state
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign full_o = (cnt_r == (AW+1)'(DEPTH));
  assign in_ready_o = !full_o;
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ssccm_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pads
  input wire ssccm_pkg::ssccm_pad_in_t pad_i,
  output ssccm_pkg::ssccm_pad_out_t pad_o,
  // Transfer state from the shifters
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  // Selected clocks and starts
  output ssccm_pkg::ssccm_clk_evt_t evt_o,
  // Received words
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [ssccm_pkg::SSCCM_WORD_W-1:0] rx_data_o,
  // Interrupt
  output logic irq_o
);
  import ssccm_pkg::*;

  logic [SSCCM_DIV_W-1:0] div_r;
  logic [SSCCM_MODE_W-1:0] tcm_r;
  logic [SSCCM_MODE_W-1:0] rcm_r;
  logic [SSCCM_ST_W-1:0] mask_r;
  logic [SSCCM_DIV_W-1:0] dcnt_r;
  logic dclk_r;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] rise;
  logic [4:0] fall;
  logic tx_own;
  logic rx_own;
  logic tx_sel;
  logic rx_sel;
  logic tx_int;
  logic rx_int;
  logic tx_prev_r;
  logic rx_prev_r;
  logic tx_fs_edge;
  logic rx_fs_edge;
  logic [SSCCM_WORD_W-1:0] shf_r;
  logic [$clog2(SSCCM_WORD_W):0] bits_r;
  logic word_vld;
  logic fifo_rdy;
  logic fifo_full;
  logic ovr_r;
  logic tfs_r;
  logic rfs_r;
  logic [SSCCM_ST_W-1:0] pend;
  logic ack_r;
  logic [31:0] rdat_r;
  logic req;
  logic stat_rd;
  ssccm_pad_out_t pad_r;
  ssccm_clk_evt_t evt_r;
  logic irq_r;

  assign req = cyc_i && stb_i && !ack_r;
  assign ack_o = ack_r;
  assign dat_o = rdat_r;
  assign pad_o = pad_r;
  assign evt_o = evt_r;
  assign irq_o = irq_r;
  assign stat_rd = req && !we_i && (adr_i == SSCCM_STAT_OFS);

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Control register writes, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= SSCCM_DIV_RST;
      tcm_r <= SSCCM_MODE_RST;
      rcm_r <= SSCCM_MODE_RST;
      mask_r <= SSCCM_MASK_RST;
    end else if (req && we_i) begin
      case (adr_i)
        SSCCM_DIV_OFS: begin
          if (sel_i[0]) div_r[7:0] <= dat_i[7:0];
          if (sel_i[1]) div_r[11:8] <= dat_i[11:8];
        end
        SSCCM_TCM_OFS: if (sel_i[0]) tcm_r <= dat_i[SSCCM_MODE_W-1:0];
        SSCCM_RCM_OFS: if (sel_i[0]) rcm_r <= dat_i[SSCCM_MODE_W-1:0];
        SSCCM_MASK_OFS: if (sel_i[0]) mask_r <= dat_i[SSCCM_ST_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h00000000;
    end else if (req && !we_i) begin
      case (adr_i)
        SSCCM_DIV_OFS: rdat_r <= {20'h00000, div_r};
        SSCCM_TCM_OFS: rdat_r <= {26'h0000000, tcm_r};
        SSCCM_RCM_OFS: rdat_r <= {26'h0000000, rcm_r};
        SSCCM_STAT_OFS: rdat_r <= {27'h0000000, pend};
        SSCCM_MASK_OFS: rdat_r <= {27'h0000000, mask_r};
        default: rdat_r <= 32'h00000000;
      endcase
    end
  end

  // Divider: each level lasts div_r cycles, idle at zero
  always_ff @(posedge clk_i) begin
    if (rst_i || div_r == SSCCM_DIV_RST) begin
      dcnt_r <= '0;
      dclk_r <= 1'b0;
    end else if (dcnt_r >= div_r - 1'b1) begin
      dcnt_r <= '0;
      dclk_r <= !dclk_r;
    end else begin
      dcnt_r <= dcnt_r + 1'b1;
    end
  end

  // Pad synchronisers with edge detection from the second stage
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pad_i[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
      assign rise[g] = s2_r[g] && !s3_r[g];
      assign fall[g] = !s2_r[g] && s3_r[g];
    end
  endgenerate

  // Source selection; the other side's own source avoids a loop
  assign tx_own = (tcm_r[SSCCM_OUT_LSB+:2] != SSCCM_OUT_NONE) ? dclk_r :
                  ((tcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_PAD) ? s2_r[1] : dclk_r);
  assign rx_own = (rcm_r[SSCCM_OUT_LSB+:2] != SSCCM_OUT_NONE) ? dclk_r :
                  ((rcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_PAD) ? s2_r[0] : dclk_r);
  assign tx_sel = (tcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_OTHER) ? rx_own :
                  ((tcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_PAD) ? s2_r[1] : dclk_r);
  assign rx_sel = (rcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_OTHER) ? tx_own :
                  ((rcm_r[SSCCM_SRC_LSB+:2] == SSCCM_SRC_PAD) ? s2_r[0] : dclk_r);
  assign tx_int = tx_sel ^ tcm_r[SSCCM_INV_BIT];
  assign rx_int = rx_sel ^ rcm_r[SSCCM_INV_BIT];
  assign tx_fs_edge = rise[3] || fall[3];
  assign rx_fs_edge = rise[2] || fall[2];

  // Internal clock levels, edges and starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_prev_r <= 1'b0;
      rx_prev_r <= 1'b0;
      evt_r <= '0;
    end else begin
      tx_prev_r <= tx_int;
      rx_prev_r <= rx_int;
      evt_r.tx_level <= tx_int;
      evt_r.tx_rise <= tx_int && !tx_prev_r;
      evt_r.tx_fall <= !tx_int && tx_prev_r;
      evt_r.rx_level <= rx_int;
      evt_r.rx_rise <= rx_int && !rx_prev_r;
      evt_r.rx_fall <= !rx_int && rx_prev_r;
      evt_r.tx_start <= tcm_r[SSCCM_SYNC_BIT] ? rx_fs_edge : tx_fs_edge;
      evt_r.rx_start <= rcm_r[SSCCM_SYNC_BIT] ? tx_fs_edge : rx_fs_edge;
    end
  end

  // Clock pads carry the uninverted clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_r <= '0;
    end else begin
      pad_r.tx_clk_o <= tx_sel;
      pad_r.rx_clk_o <= rx_sel;
      pad_r.tx_clk_oe <= (tcm_r[SSCCM_OUT_LSB+:2] == SSCCM_OUT_CONT) ||
        ((tcm_r[SSCCM_OUT_LSB+:2] == SSCCM_OUT_XFER) && tx_active_i);
      pad_r.rx_clk_oe <= (rcm_r[SSCCM_OUT_LSB+:2] == SSCCM_OUT_CONT) ||
        ((rcm_r[SSCCM_OUT_LSB+:2] == SSCCM_OUT_XFER) && rx_active_i);
    end
  end

  // Receive bits gathered into words; a full buffer holds the shifter
  assign word_vld = (bits_r == ($clog2(SSCCM_WORD_W)+1)'(SSCCM_WORD_W));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shf_r <= '0;
      bits_r <= '0;
    end else if (word_vld) begin
      if (fifo_rdy) begin
        bits_r <= '0;
      end
    end else if (rx_active_i && rx_int && !rx_prev_r) begin
      shf_r <= {shf_r[SSCCM_WORD_W-2:0], s2_r[4]};
      bits_r <= bits_r + 1'b1;
    end
  end

  ssccm_fifo #(
    .WIDTH(SSCCM_WORD_W),
    .DEPTH(SSCCM_FIFO_D)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(word_vld),
    .in_ready_o(fifo_rdy),
    .in_data_i(shf_r),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o),
    .full_o(fifo_full)
  );

  // Sticky events cleared by a status read; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_r <= 1'b0;
      tfs_r <= 1'b0;
      rfs_r <= 1'b0;
    end else begin
      ovr_r <= (word_vld && !fifo_rdy && rx_int && !rx_prev_r && rx_active_i) ||
               (ovr_r && !stat_rd);
      tfs_r <= tx_fs_edge || (tfs_r && !stat_rd);
      rfs_r <= rx_fs_edge || (rfs_r && !stat_rd);
    end
  end

  assign pend = {rfs_r, tfs_r, ovr_r, fifo_full, rx_valid_o};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(pend & mask_r);
    end
  end
endmodule

// ==== ssccm_top_chk.sv ====
/*
  Port checks for the serial clock management top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ssccm_top_chk (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pads and clocks
  input wire ssccm_pkg::ssccm_pad_in_t pad_i,
  input wire ssccm_pkg::ssccm_pad_out_t pad_o,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire ssccm_pkg::ssccm_clk_evt_t evt_o,
  // Stream and interrupt
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [ssccm_pkg::SSCCM_WORD_W-1:0] rx_data_o,
  input wire logic irq_o
);
  import ssccm_pkg::*;
  default clocking dclk @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
  a_dat_hold: assert property (!(cyc_i && stb_i && !we_i) |=> $stable(dat_o))
    else $error("read data moved");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !rx_valid_o
    && !pad_o.tx_clk_oe && !pad_o.rx_clk_oe) else $error("outputs active after reset");
  a_tx_edge_excl: assert property (!(evt_o.tx_rise && evt_o.tx_fall))
    else $error("tx rise and fall together");
  a_rx_rise_gap: assert property (evt_o.rx_rise |=> !evt_o.rx_rise)
    else $error("rx rises back to back");
  a_rx_word_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o
    && $stable(rx_data_o)) else $error("rx word dropped");
endmodule
bind ssccm_top ssccm_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .pad_i(pad_i), .pad_o(pad_o), .tx_active_i(tx_active_i),
  .rx_active_i(rx_active_i), .evt_o(evt_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o), .irq_o(irq_o));

// ==== tb_sync_serial_clock_management.sv ====
/*
  Self-checking bench: registers, divider, clock modes, sources, buffer, interrupt.
  Assumes ssccm_pkg, ssccm_top, ssccm_peer and the bound checker.
*/
`timescale 1ns/1ps
module tb_sync_serial_clock_management;
  import ssccm_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, txa = 0, rxa = 0, rdy = 0, en = 0;
  logic side = 0, tfp = 0, rfp = 0, ack_o, rx_valid_o, irq_o, ck, rd;
  logic [7:0] adr = 8'h00, rx_data_o;
  logic [31:0] dat = 32'h0, dat_o, q;
  ssccm_pad_out_t pad_o;
  ssccm_pad_in_t pin;
  ssccm_clk_evt_t evt_o;
  int failures = 0, check_count = 0, txr, rxr, txh, inv, agr, txf, ts, rs;
  int dv[3] = '{1, 3, 4095};
  int sc[4][4] = '{'{2, 1, 10, 10}, '{0, 2, 20, 10}, '{1, 2, 10, 10}, '{1, 0, 20, 20}};
  always #5 clk_i = ~clk_i;
  // A driven clock pad loops back; otherwise the peer's clock stands on it
  assign pin = '{rd: rd, tx_fs: tfp, rx_fs: rfp,
    tx_clk: pad_o.tx_clk_oe ? pad_o.tx_clk_o : ck,
    rx_clk: pad_o.rx_clk_oe ? pad_o.rx_clk_o : ck};
  ssccm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .pad_i(pin),
    .pad_o(pad_o), .tx_active_i(txa), .rx_active_i(rxa), .evt_o(evt_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rdy), .rx_data_o(rx_data_o), .irq_o(irq_o));
  ssccm_peer u_peer (.clk_i(clk_i), .en_i(en), .ck_o(ck), .rd_o(rd));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin
      failures++;
      give_verdict();
    end
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic meas(input int n);
    {txr, rxr, txh, inv, agr, txf, ts, rs} = '0;
    repeat (n) begin
      @(posedge clk_i);
      txr += evt_o.tx_rise;
      rxr += evt_o.rx_rise;
      txh += evt_o.tx_level;
      inv += (evt_o.tx_level === evt_o.rx_level);
      agr += side ? (pad_o.rx_clk_o === evt_o.tx_level) : (pad_o.tx_clk_o === evt_o.rx_level);
      txf += evt_o.tx_fall + evt_o.rx_fall;
      ts += evt_o.tx_start;
      rs += evt_o.rx_start;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 24; a += 4) rdc(8'(a), 32'h0);
    bus(1'b1, SSCCM_DIV_OFS, 32'hFFFF_FFFF);
    rdc(SSCCM_DIV_OFS, 32'h0000_0FFF);
    bus(1'b1, SSCCM_DIV_OFS, 32'h0);
    meas(40);
    chk(txr + rxr, 0);
    $display("register test done");
    foreach (dv[i]) begin
      bus(1'b1, SSCCM_DIV_OFS, dv[i]);
      meas(2 * dv[i]);
      meas(4 * dv[i]);
      chk(txr, 2);
      chk(rxr, 2);
      chk(txh, 2 * dv[i]);
      chk(txf, 4);
    end
    $display("divider test done");
    for (int s = 0; s < 2; s++) begin
      side = s[0];
      bus(1'b1, SSCCM_DIV_OFS, 32'h8);
      // Continuous output never with its own pad as source
      bus(1'b1, SSCCM_TCM_OFS, s ? 32'h0 : 32'h14);
      bus(1'b1, SSCCM_RCM_OFS, s ? 32'h14 : 32'h0);
      meas(16);
      meas(80);
      chk(inv, 0);
      chk(agr > 50, 1);
      chk(s ? pad_o.rx_clk_oe : pad_o.tx_clk_oe, 1);
      bus(1'b1, SSCCM_DIV_OFS, 32'h0);
      bus(1'b1, s ? SSCCM_RCM_OFS : SSCCM_TCM_OFS, 32'h8);
      for (int a = 0; a < 2; a++) begin
        if (s) rxa <= a[0];
        else txa <= a[0];
        repeat (3) @(posedge clk_i);
        chk(s ? pad_o.rx_clk_oe : pad_o.tx_clk_oe, a[0]);
      end
      bus(1'b1, s ? SSCCM_RCM_OFS : SSCCM_TCM_OFS, 32'h0);
      chk(s ? pad_o.rx_clk_oe : pad_o.tx_clk_oe, 0);
      txa <= 1'b0;
      rxa <= 1'b0;
    end
    $display("clock mode test done");
    bus(1'b1, SSCCM_DIV_OFS, 32'h2);
    en <= 1'b1;
    foreach (sc[i]) begin
      bus(1'b1, SSCCM_TCM_OFS, sc[i][0]);
      bus(1'b1, SSCCM_RCM_OFS, sc[i][1]);
      meas(16);
      meas(80);
      chk(txr, sc[i][2]);
      chk(rxr, sc[i][3]);
    end
    en <= 1'b0;
    $display("source test done");
    bus(1'b1, SSCCM_RCM_OFS, 32'h2);
    rxa <= 1'b1;
    en <= 1'b1;
    repeat (1200) @(posedge clk_i);
    en <= 1'b0;
    rxa <= 1'b0;
    chk(irq_o, 0);
    bus(1'b1, SSCCM_MASK_OFS, 32'h4);
    chk(irq_o, 1);
    rdc(SSCCM_STAT_OFS, 32'h7);
    rdc(SSCCM_STAT_OFS, 32'h3);
    chk(irq_o, 0);
    bus(1'b1, SSCCM_MASK_OFS, 32'h1);
    // The word held in the shifter lands once the first pop frees a slot
    for (int k = 0; k < 17; k++) begin
      chk(irq_o, 1);
      chk(rx_valid_o, 1);
      chk(rx_data_o, k);
      rdy <= 1'b1;
      @(posedge clk_i);
      rdy <= 1'b0;
      @(posedge clk_i);
    end
    chk(rx_valid_o, 0);
    rdc(SSCCM_STAT_OFS, 32'h0);
    chk(irq_o, 0);
    $display("buffer test done");
    bus(1'b1, SSCCM_RCM_OFS, 32'h20);
    tfp <= 1'b1;
    meas(10);
    chk(ts, 1);
    chk(rs, 1);
    rfp <= 1'b1;
    meas(10);
    chk(ts + rs, 0);
    rdc(SSCCM_STAT_OFS, 32'h18);
    rdc(SSCCM_STAT_OFS, 32'h0);
    $display("start test done");
    give_verdict();
  end
endmodule
